// >>> sosc_pkg.sv
// Constants, register map and carrier types for the standby and oscillation stabilization controller.
// Assumes an APB master with 32-bit data and a CPU core that signals its standby instructions.
package sosc_pkg;
    localparam int CNT_W = 16;
    localparam int STAT_W = 5;
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_MAX = 3'h4;
    localparam logic [2:0] SEL_RESET = 3'h4;
    localparam int STAB_FIRST_LOG2_DEFAULT = 11;

    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SELECT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h0c;

    localparam int CTRL_LSO_RUN_BIT = 0;
    localparam logic CTRL_LSO_RUN_RESET = 1'b1;
    localparam int MODE_STOP_BIT = 0;
    localparam int MODE_HALT_BIT = 1;
    localparam int MODE_WAIT_BIT = 2;
    localparam int MODE_LSO_BIT = 3;
    localparam int MODE_MAIN_OSC_BIT = 4;
    localparam int MODE_SUB_OSC_BIT = 5;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT,
        ST_STOP,
        ST_WAIT,
        ST_HALT_WAIT
    } sosc_state_t;

    typedef struct packed {
        logic stop_instr;
        logic halt_instr;
        logic irq_pending;
        logic on_subclock;
    } sosc_core_t;

    typedef struct packed {
        logic [APB_AW-1:0] paddr;
        logic pwrite;
        logic [APB_DW-1:0] pwdata;
    } sosc_apb_req_t;
endpackage : sosc_pkg

// >>> sosc_stab_counter.sv
// Oscillation stabilization counter with its sticky threshold status bits.
// Assumes the controller pulses clear on STOP entry and raises enable only while the oscillator runs.
`timescale 1ns/1ps
`default_nettype none
module sosc_stab_counter #(
    parameter int unsigned FIRST_LOG2 = sosc_pkg::STAB_FIRST_LOG2_DEFAULT
) (
    input wire logic clock_in, // System clock.
    input wire logic rst_in, // Asynchronous reset, active high.
    input wire logic ce_in, // Clock enable.
    input wire logic clear_in, // Restart counting and clear status.
    input wire logic enable_in, // Oscillator running, count allowed.
    input wire logic [sosc_pkg::SEL_W-1:0] sel_in, // Selected wait index, already clamped.
    output logic [sosc_pkg::STAT_W-1:0] status_out, // Threshold status bits.
    output logic done_out // Selected wait has elapsed.
);
    import sosc_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [STAT_W-1:0] status_reg;
    logic [STAT_W-1:0] status_next;
    logic done;

    function automatic logic [CNT_W-1:0] thr(input logic [SEL_W-1:0] k);
        thr = CNT_W'(32'h1 << (FIRST_LOG2 + 32'(k)));
    endfunction : thr

    assign done = (cnt_reg >= thr(sel_in));

    always_comb begin
        cnt_next = cnt_reg;
        if (clear_in) begin
            cnt_next = '0;
        end else if (enable_in && !done) begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    for (genvar k = 0; k < STAT_W; k++) begin : g_bit
        // A bit past the selected wait is masked by sel_in, so it stays clear even if the count passes its threshold.
        always_comb begin
            if (clear_in) begin
                status_next[k] = 1'b0;
            end else begin
                status_next[k] = status_reg[k] | ((cnt_reg >= thr(SEL_W'(k))) && (SEL_W'(k) <= sel_in));
            end
        end

        property p_mask_high;
            @(posedge clock_in) disable iff (rst_in)
            (ce_in && !clear_in && !status_reg[k] && (SEL_W'(k) > sel_in)) |=> !status_reg[k];
        endproperty
        a_mask_high: assert property (p_mask_high) else $error("status bit set beyond selected wait");
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
            status_reg <= '0;
        end else if (ce_in) begin
            cnt_reg <= cnt_next;
            status_reg <= status_next;
        end
    end

    assign status_out = status_reg;
    assign done_out = done;

    property p_sticky;
        @(posedge clock_in) disable iff (rst_in)
        (ce_in && !clear_in) |=> ((status_reg & $past(status_reg)) == $past(status_reg));
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");

    property p_in_order;
        @(posedge clock_in) disable iff (rst_in)
        ((status_reg & (status_reg + STAT_W'(1))) == '0);
    endproperty
    a_in_order: assert property (p_in_order) else $error("status bits not set from the shortest");

    property p_stop_at_limit;
        @(posedge clock_in) disable iff (rst_in)
        (done && !clear_in) |=> $stable(cnt_reg);
    endproperty
    a_stop_at_limit: assert property (p_stop_at_limit) else $error("counter ran past selected wait");

    property p_no_osc_no_count;
        @(posedge clock_in) disable iff (rst_in)
        (!enable_in && !clear_in) |=> $stable(cnt_reg);
    endproperty
    a_no_osc_no_count: assert property (p_no_osc_no_count) else $error("counted before oscillation");

    property p_clear;
        @(posedge clock_in) disable iff (rst_in)
        (ce_in && clear_in) |=> (cnt_reg == '0) && (status_reg == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("stop entry did not restart counter");
endmodule : sosc_stab_counter
`default_nettype wire

// >>> sosc_standby_ctrl.sv
// Standby controller: RUN, HALT and STOP sequencing, stabilization wait and APB registers.
// Assumes core_in is synchronous to clock_in and that the APB master follows the usual two-phase protocol.
`timescale 1ns/1ps
`default_nettype none
module sosc_standby_ctrl #(
    parameter int unsigned STAB_FIRST_LOG2 = sosc_pkg::STAB_FIRST_LOG2_DEFAULT
) (
    input wire logic clock_in, // 20 MHz system clock.
    input wire logic rst_in, // Asynchronous reset, active high.
    input wire logic ce_in, // Clock enable, freezes all state when low.
    input wire sosc_pkg::sosc_core_t core_in, // Standby requests and status from the CPU core.
    input wire logic osc_started_in, // Crystal oscillation has started.
    input wire logic psel_in, // APB select.
    input wire logic penable_in, // APB enable.
    input wire sosc_pkg::sosc_apb_req_t apb_req_in, // APB address, direction and write data.
    output logic [sosc_pkg::APB_DW-1:0] prdata_out, // APB read data.
    output logic pready_out, // APB ready.
    output logic pslverr_out, // APB error on unmapped address.
    output logic cpu_clk_en_out, // CPU clock runs.
    output logic main_osc_en_out, // Main oscillator enable.
    output logic sub_osc_en_out, // Subsystem oscillator enable.
    output logic lso_en_out, // Internal low-speed oscillator enable.
    output logic stop_mode_out, // In STOP or its stabilization wait.
    output logic halt_mode_out // In HALT or the halt-style wait.
);
    import sosc_pkg::*;

    sosc_state_t state_reg;
    sosc_state_t state_next;
    logic lso_run_reg;
    logic lso_run_next;
    logic [SEL_W-1:0] sel_reg;
    logic [SEL_W-1:0] sel_next;
    logic lso_en_reg;
    logic lso_en_next;
    logic main_osc_reg;
    logic main_osc_next;
    logic [APB_DW-1:0] prdata_reg;
    logic [APB_DW-1:0] prdata_next;

    logic stab_clear;
    logic stab_enable;
    logic stab_done;
    logic [SEL_W-1:0] sel_eff;
    logic [STAT_W-1:0] stab_status;
    logic stop_ok;
    logic setup;
    logic access;
    logic mapped;
    logic [APB_DW-1:0] mode_word;

    // Selections beyond the longest threshold act as the longest one.
    assign sel_eff = (sel_reg > SEL_MAX) ? SEL_MAX : sel_reg;

    // STOP is refused while the CPU runs from the subsystem clock.
    assign stop_ok = core_in.stop_instr && !core_in.on_subclock;
    assign stab_clear = (state_reg == ST_RUN) && stop_ok;

    // The crystal wait starts only once oscillation is seen; in the halt-style wait the oscillator never stopped.
    assign stab_enable = ((state_reg == ST_WAIT) && osc_started_in) || (state_reg == ST_HALT_WAIT);

    sosc_stab_counter #(
        .FIRST_LOG2(STAB_FIRST_LOG2)
    ) u_counter (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .clear_in(stab_clear),
        .enable_in(stab_enable),
        .sel_in(sel_eff),
        .status_out(stab_status),
        .done_out(stab_done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (stop_ok && core_in.irq_pending) begin
                    state_next = ST_HALT_WAIT;
                end else if (stop_ok) begin
                    state_next = ST_STOP;
                end else if (core_in.halt_instr) begin
                    state_next = ST_HALT;
                end
            end
            ST_HALT: begin
                if (core_in.irq_pending) begin
                    state_next = ST_RUN;
                end
            end
            ST_STOP: begin
                if (core_in.irq_pending) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT, ST_HALT_WAIT: begin
                if (stab_done) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_comb begin
        // The low-speed oscillator holds its state across STOP and its wait, whatever software asks.
        if ((state_reg == ST_STOP) || (state_reg == ST_WAIT)) begin
            lso_en_next = lso_en_reg;
        end else begin
            lso_en_next = lso_run_reg;
        end
        main_osc_next = (state_next != ST_STOP);
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_RUN;
            lso_en_reg <= CTRL_LSO_RUN_RESET;
            main_osc_reg <= 1'b1;
        end else if (ce_in) begin
            state_reg <= state_next;
            lso_en_reg <= lso_en_next;
            main_osc_reg <= main_osc_next;
        end
    end

    // APB slave: read data is latched in the setup cycle and the access completes in one cycle.
    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in && ce_in;

    always_comb begin
        if (apb_req_in.paddr == ADDR_CTRL) begin
            mapped = 1'b1;
        end else if (apb_req_in.paddr == ADDR_SELECT) begin
            mapped = 1'b1;
        end else if (apb_req_in.paddr == ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (apb_req_in.paddr == ADDR_MODE) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        mode_word = '0;
        mode_word[MODE_STOP_BIT] = stop_mode_out;
        mode_word[MODE_HALT_BIT] = halt_mode_out;
        mode_word[MODE_WAIT_BIT] = (state_reg == ST_WAIT) || (state_reg == ST_HALT_WAIT);
        mode_word[MODE_LSO_BIT] = lso_en_reg;
        mode_word[MODE_MAIN_OSC_BIT] = main_osc_reg;
        mode_word[MODE_SUB_OSC_BIT] = sub_osc_en_out;
    end

    always_comb begin
        prdata_next = prdata_reg;
        if (setup) begin
            if (apb_req_in.pwrite) begin
                prdata_next = '0;
            end else if (apb_req_in.paddr == ADDR_CTRL) begin
                prdata_next = APB_DW'(lso_run_reg) << CTRL_LSO_RUN_BIT;
            end else if (apb_req_in.paddr == ADDR_SELECT) begin
                prdata_next = APB_DW'(sel_reg);
            end else if (apb_req_in.paddr == ADDR_STATUS) begin
                prdata_next = APB_DW'(stab_status);
            end else if (apb_req_in.paddr == ADDR_MODE) begin
                prdata_next = mode_word;
            end else begin
                prdata_next = '0;
            end
        end
    end

    always_comb begin
        lso_run_next = lso_run_reg;
        sel_next = sel_reg;
        if (access && apb_req_in.pwrite) begin
            if (apb_req_in.paddr == ADDR_CTRL) begin
                lso_run_next = apb_req_in.pwdata[CTRL_LSO_RUN_BIT];
            end else if (apb_req_in.paddr == ADDR_SELECT) begin
                sel_next = apb_req_in.pwdata[SEL_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            lso_run_reg <= CTRL_LSO_RUN_RESET;
            sel_reg <= SEL_RESET;
            prdata_reg <= '0;
        end else if (ce_in) begin
            lso_run_reg <= lso_run_next;
            sel_reg <= sel_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = ce_in;
    assign pslverr_out = psel_in && penable_in && !mapped;

    assign cpu_clk_en_out = (state_reg == ST_RUN);
    assign main_osc_en_out = main_osc_reg;
    assign sub_osc_en_out = 1'b1;
    assign lso_en_out = lso_en_reg;
    assign stop_mode_out = (state_reg == ST_STOP) || (state_reg == ST_WAIT);
    assign halt_mode_out = (state_reg == ST_HALT) || (state_reg == ST_HALT_WAIT);

    property p_no_stop_on_sub;
        @(posedge clock_in) disable iff (rst_in)
        (ce_in && (state_reg == ST_RUN) && core_in.stop_instr && core_in.on_subclock && !core_in.halt_instr)
            |=> (state_reg == ST_RUN) && main_osc_en_out;
    endproperty
    a_no_stop_on_sub: assert property (p_no_stop_on_sub) else $error("STOP taken on subsystem clock");

    property p_halt_any_clock;
        @(posedge clock_in) disable iff (rst_in)
        (ce_in && (state_reg == ST_RUN) && core_in.halt_instr && !core_in.stop_instr)
            |=> halt_mode_out && !cpu_clk_en_out;
    endproperty
    a_halt_any_clock: assert property (p_halt_any_clock) else $error("HALT not entered");

    property p_sub_osc_on;
        @(posedge clock_in) disable iff (rst_in)
        sub_osc_en_out && mode_word[MODE_SUB_OSC_BIT];
    endproperty
    a_sub_osc_on: assert property (p_sub_osc_on) else $error("subsystem oscillator stopped");

    property p_pending_to_halt;
        @(posedge clock_in) disable iff (rst_in)
        (ce_in && (state_reg == ST_RUN) && stop_ok && core_in.irq_pending)
            |=> (state_reg == ST_HALT_WAIT) && main_osc_en_out;
    endproperty
    a_pending_to_halt: assert property (p_pending_to_halt) else $error("pending interrupt did not drop to HALT");

    property p_resume_after_wait;
        @(posedge clock_in) disable iff (rst_in)
        (ce_in && (state_reg == ST_HALT_WAIT) && stab_done) |=> cpu_clk_en_out;
    endproperty
    a_resume_after_wait: assert property (p_resume_after_wait) else $error("no resume after wait");

    property p_lso_hold;
        @(posedge clock_in) disable iff (rst_in)
        ((state_reg == ST_STOP) && $past(state_reg == ST_STOP)) |-> $stable(lso_en_out);
    endproperty
    a_lso_hold: assert property (p_lso_hold) else $error("low-speed oscillator changed in STOP");

    property p_wait_blocks_on_osc;
        @(posedge clock_in) disable iff (rst_in)
        ((state_reg == ST_WAIT) && !osc_started_in && !stab_done) |=> (state_reg == ST_WAIT);
    endproperty
    a_wait_blocks_on_osc: assert property (p_wait_blocks_on_osc) else $error("wait ended before oscillation");
endmodule : sosc_standby_ctrl
`default_nettype wire

// >>> sosc_core_model.sv
// Model of the CPU core and the crystal oscillator that face the standby controller.
// Assumes the bench calls its tasks from one process, synchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
module sosc_core_model (
    input wire logic clock_in, // System clock.
    input wire logic rst_in, // Asynchronous reset, active high.
    input wire logic main_osc_en_in, // Main oscillator enable from the controller.
    input wire logic [7:0] osc_delay_in, // Cycles before crystal oscillation starts.
    output var sosc_pkg::sosc_core_t core_out, // Standby requests and clock status.
    output logic osc_started_out // Crystal oscillation has started.
);
    import sosc_pkg::*;
    logic [7:0] start_cnt;
    initial core_out = '0;
    // The crystal takes a while to start after each enable, and that time is not part of the wait.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            start_cnt <= 8'h00;
            osc_started_out <= 1'b1;
        end else if (!main_osc_en_in) begin
            start_cnt <= 8'h00;
            osc_started_out <= 1'b0;
        end else if (start_cnt >= osc_delay_in) begin
            osc_started_out <= 1'b1;
        end else begin
            start_cnt <= start_cnt + 8'h01;
        end
    end
    // One-cycle instruction pulse; the caller has already stopped main-clock peripherals,
    // cleared the converter bits and programmed the wait time, as a real core must.
    task automatic pulse(input logic stop, input logic halt);
        @(posedge clock_in);
        core_out.stop_instr <= stop;
        core_out.halt_instr <= halt;
        @(posedge clock_in);
        core_out.stop_instr <= 1'b0;
        core_out.halt_instr <= 1'b0;
    endtask : pulse
    task automatic set_level(input logic irq, input logic sub);
        @(posedge clock_in);
        core_out.irq_pending <= irq;
        core_out.on_subclock <= sub;
    endtask : set_level
endmodule : sosc_core_model
`default_nettype wire

// >>> sosc_standby_ctrl_test.sv
// Self-checking bench for the standby controller with a small stabilization parameter.
// Assumes the core model file and the design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module sosc_standby_ctrl_test;
    import sosc_pkg::*;
    localparam int L = 2;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic ce = 1'b1;
    sosc_apb_req_t req = '0;
    sosc_core_t core;
    logic osc_started;
    logic [7:0] osc_delay = 8'h00;
    logic [31:0] prdata, rd_val;
    logic pready, pslverr, rd_err, cpu_clk_en, main_osc_en, sub_osc_en, lso_en, stop_mode, halt_mode;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    always #25 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;
    sosc_standby_ctrl #(.STAB_FIRST_LOG2(L)) i_sosc_standby_ctrl (.clock_in(clock_in), .rst_in(rst_in),
        .ce_in(ce), .core_in(core), .osc_started_in(osc_started), .psel_in(psel), .penable_in(penable),
        .apb_req_in(req), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .cpu_clk_en_out(cpu_clk_en), .main_osc_en_out(main_osc_en), .sub_osc_en_out(sub_osc_en),
        .lso_en_out(lso_en), .stop_mode_out(stop_mode), .halt_mode_out(halt_mode));
    sosc_core_model i_sosc_core_model (.clock_in(clock_in), .rst_in(rst_in), .main_osc_en_in(main_osc_en),
        .osc_delay_in(osc_delay), .core_out(core), .osc_started_out(osc_started));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock_in);
        psel <= 1'b1;
        req <= '{paddr: a, pwrite: w, pwdata: d};
        @(posedge clock_in);
        penable <= 1'b1;
        // Only the watchdog ends a transfer that never sees ready.
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wait_cyc
    function automatic logic [31:0] mode_word(input logic stp, input logic hlt, input logic wt, input logic lso,
                                              input logic mn);
        return {26'h0, 1'b1, mn, lso, wt, hlt, stp};
    endfunction : mode_word
    // Enters STOP with the given selection, optionally rewrites the low-speed enable during STOP.
    task automatic run_stop(input logic [2:0] sel, input logic [7:0] d, input logic lso_test);
        int lim, s, t0;
        logic [31:0] r;
        s = (sel > 3'h4) ? 4 : int'(sel);
        lim = 1 << (L + s);
        r = $urandom;
        r[2:0] = sel;
        apb(ADDR_SELECT, 1'b1, r);
        osc_delay <= d;
        i_sosc_core_model.pulse(1'b1, 1'b0);
        apb(ADDR_MODE, 1'b0, 32'h0);
        check("mode in stop", rd_val, mode_word(1'b1, 1'b0, 1'b0, !lso_test, 1'b0));
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("status after stop", rd_val, 32'h0);
        if (lso_test) begin
            apb(ADDR_CTRL, 1'b1, 32'h1);
            wait_cyc(2);
            check("lso held in stop", {31'h0, lso_en}, 32'h0);
        end
        i_sosc_core_model.set_level(1'b1, 1'b0);
        t0 = cyc;
        if (s == 4) begin
            wait_cyc(int'(d) + 12);
            apb(ADDR_STATUS, 1'b0, 32'h0);
            check("status mid wait", rd_val, 32'h3);
            apb(ADDR_MODE, 1'b0, 32'h0);
            check("mode mid wait", rd_val, mode_word(1'b1, 1'b0, 1'b1, !lso_test, 1'b1));
        end
        while (cpu_clk_en !== 1'b1 && cyc - t0 < 2000) @(posedge clock_in);
        check("wait length", {31'h0, (cyc - t0 >= lim + int'(d)) && (cyc - t0 <= lim + int'(d) + 4)}, 32'h1);
        i_sosc_core_model.set_level(1'b0, 1'b0);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("status after wait", rd_val, (32'h1 << (s + 1)) - 32'h1);
    endtask : run_stop
    initial begin
        repeat (50000) @(posedge clock_in);
        n_mismatch++;
        results();
    end
    initial begin
        int t0;
        void'($urandom(19));
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        apb(ADDR_CTRL, 1'b0, 32'h0);
        check("ctrl reset", rd_val, 32'h1);
        apb(ADDR_SELECT, 1'b0, 32'h0);
        check("select reset", rd_val, 32'h4);
        apb(ADDR_MODE, 1'b0, 32'h0);
        check("mode reset", rd_val, mode_word(1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
        apb(ADDR_STATUS, 1'b1, 32'h1f);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("status read only", rd_val, 32'h0);
        apb(8'h10, 1'b0, 32'h0);
        check("unmapped read", {rd_err, rd_val[30:0]}, 32'h80000000);
        // Selection is only written while no wait is running.
        for (int s = 0; s < 5; s++) run_stop(3'(s), 8'($urandom_range(0, 20)), 1'b0);
        apb(ADDR_CTRL, 1'b1, 32'h0);
        run_stop(3'($urandom_range(5, 7)), 8'h03, 1'b1);
        wait_cyc(3);
        check("lso follows ctrl", {31'h0, lso_en}, 32'h1);
        i_sosc_core_model.set_level(1'b0, 1'b1);
        i_sosc_core_model.pulse(1'b1, 1'b0);
        wait_cyc(2);
        check("stop refused on subclock", {30'h0, stop_mode, cpu_clk_en}, 32'h1);
        i_sosc_core_model.pulse(1'b0, 1'b1);
        wait_cyc(2);
        check("halt on subclock", {29'h0, halt_mode, main_osc_en, sub_osc_en}, 32'h7);
        i_sosc_core_model.set_level(1'b1, 1'b1);
        wait_cyc(3);
        check("halt release", {31'h0, cpu_clk_en}, 32'h1);
        i_sosc_core_model.set_level(1'b0, 1'b0);
        apb(ADDR_SELECT, 1'b1, 32'h1);
        i_sosc_core_model.set_level(1'b1, 1'b0);
        i_sosc_core_model.pulse(1'b1, 1'b0);
        t0 = cyc;
        wait_cyc(1);
        check("stop drops to halt", {29'h0, halt_mode, stop_mode, main_osc_en}, 32'h5);
        // Hold the clock enable low for five cycles; the wait must stretch by that much, and the check allows up to four cycles more.
        ce <= 1'b0;
        wait_cyc(5);
        check("ready while frozen", {30'h0, pready, halt_mode}, 32'h1);
        ce <= 1'b1;
        while (cpu_clk_en !== 1'b1 && cyc - t0 < 2000) @(posedge clock_in);
        check("halt wait length", {31'h0, (cyc - t0 >= 13) && (cyc - t0 <= 17)}, 32'h1);
        i_sosc_core_model.set_level(1'b0, 1'b0);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("status after halt wait", rd_val, 32'h3);
        results();
    end
endmodule : sosc_standby_ctrl_test
`default_nettype wire
